// >>> hw/sfl_pkg.sv
// Shared constants and types for the frame, loop and alternate status block
`default_nettype none
package sfl_pkg;
  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W  = 4;

  // ----------------------------------------------------------------
  // Offsets (alternate map bank select picks the meaning)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_ALT_STATUS = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_ALT_IRQ_EN = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_FRAME      = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_ALT_DETECT = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_STATUS2    = 3'h5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned FC_RETURN   = 7;
  localparam int unsigned FC_HALT     = 6;
  localparam int unsigned FC_SRC      = 5;
  localparam int unsigned FC_NINE     = 4;
  localparam int unsigned FC_WAKE     = 3;
  localparam int unsigned FC_IDLE     = 2;
  localparam int unsigned FC_PAR_ON   = 1;
  localparam int unsigned FC_PAR_ODD  = 0;
  localparam int unsigned AS_EDGE     = 7;
  localparam int unsigned AS_MVAL     = 2;
  localparam int unsigned AS_MISM     = 1;
  localparam int unsigned AS_BREAK    = 0;
  localparam int unsigned DC_MODE_LO  = 1;
  localparam int unsigned DC_BREAK_EN = 0;
  localparam int unsigned S2_ALTERNATE_MAP_SELECT     = 7;
  localparam int unsigned S2_RECEIVE_POLARITY    = 3;

  // ----------------------------------------------------------------
  // Masks and reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] AS_FLAG_MASK = 8'h83;
  localparam logic [DATA_W-1:0] IE_MASK      = 8'h83;
  localparam logic [DATA_W-1:0] DC_MASK      = 8'h07;
  localparam logic [DATA_W-1:0] S2_MASK      = 8'h88;
  localparam logic [DATA_W-1:0] RST_VAL      = 8'h00;

  // ----------------------------------------------------------------
  // Mismatch sampling modes, ticks and frame lengths
  // ----------------------------------------------------------------
  localparam logic [1:0] MM_OFF   = 2'h0;
  localparam logic [1:0] MM_EARLY = 2'h1;
  localparam logic [1:0] MM_LATE  = 2'h2;
  localparam logic [CNT_W-1:0] TICK_EARLY = 4'h9;
  localparam logic [CNT_W-1:0] TICK_LATE  = 4'hD;
  localparam logic [CNT_W-1:0] FRAME_LEN8 = 4'hA;
  localparam logic [CNT_W-1:0] FRAME_LEN9 = 4'hB;
  localparam logic [CNT_W-1:0] CNT_ONE    = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 4'h0;

  typedef enum logic [2:0] {
    SFL_SEL_NONE,
    SFL_SEL_FRAME,
    SFL_SEL_ALT_STATUS,
    SFL_SEL_ALT_IRQ,
    SFL_SEL_ALT_DETECT,
    SFL_SEL_STATUS2
  } sfl_sel_t;
endpackage : sfl_pkg
`default_nettype wire

// >>> hw/sfl_pin_sync.sv
// Two-flop synchroniser for the receive and transmit pin levels
`timescale 1ns/1ps
`default_nettype none
module sfl_pin_sync (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] pins_i,
  output logic      [1:0] pins_o
);
  logic [1:0] meta_reg;
  logic [1:0] sync_reg;

  // Pins idle high, so reset to the idle level
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= 2'h3;
      sync_reg <= 2'h3;
    end else begin
      meta_reg <= pins_i;
      sync_reg <= meta_reg;
    end
  end

  assign pins_o = sync_reg;
endmodule : sfl_pin_sync
`default_nettype wire

// >>> hw/sfl_top.sv
// Frame format, loop routing and alternate status block of a serial port
//
// Function
// - Loop mode detaches pin, feeds transmitter back
// - Halt-in-wait bit disables block in wait
// - Source bit picks internal or single-wire return
// - Length bit selects eight or nine data bits
// - Wake bit picks idle or address mark
// - Idle count starts after start or stop
// - Parity bit sits in character MSB
// - Parity select chooses even or odd
// - Active receive edge sets edge flag
// - Mismatch captures sampled receive level
// - Enabled mismatch check sets mismatch flag
// - Enabled break detector sets break flag
// - Frame control reachable only in normal bank
// - Alternate status reachable only in alternate bank
// - Map select bit switches register bank
// - Mismatch mode picks tick nine or thirteen
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module sfl_top (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rd_data_o,
  output logic            irq_o,
  input  wire logic       rx_pin_i,
  input  wire logic       tx_pin_i,
  input  wire logic       tx_serial_i,
  input  wire logic       tx_busy_i,
  input  wire logic       tx_tick_i,
  input  wire logic [3:0] tx_tick_num_i,
  input  wire logic       rx_enable_i,
  input  wire logic       rx_bit_strobe_i,
  input  wire logic       rx_stop_i,
  input  wire logic       rx_char_valid_i,
  input  wire logic [8:0] rx_char_i,
  input  wire logic [8:0] tx_char_i,
  input  wire logic       wait_mode_i,
  output logic            rx_routed_o,
  output logic            module_enable_o,
  output logic            nine_bit_o,
  output logic            parity_on_o,
  output logic            tx_parity_o,
  output logic            parity_error_o,
  output logic            idle_detect_o,
  output logic            wake_o
);
  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic sfl_pkg::sfl_sel_t decode(
    input logic [2:0] a,
    input logic       alternate_map_select
  );
    decode = sfl_pkg::SFL_SEL_NONE;
    if (a == sfl_pkg::OFS_STATUS2) begin
      decode = sfl_pkg::SFL_SEL_STATUS2;
    end else if (!alternate_map_select && a == sfl_pkg::OFS_FRAME) begin
      decode = sfl_pkg::SFL_SEL_FRAME;
    end else if (alternate_map_select && a == sfl_pkg::OFS_ALT_STATUS) begin
      decode = sfl_pkg::SFL_SEL_ALT_STATUS;
    end else if (alternate_map_select && a == sfl_pkg::OFS_ALT_IRQ_EN) begin
      decode = sfl_pkg::SFL_SEL_ALT_IRQ;
    end else if (alternate_map_select && a == sfl_pkg::OFS_ALT_DETECT) begin
      decode = sfl_pkg::SFL_SEL_ALT_DETECT;
    end
  endfunction : decode

  // Parity over the data bits below the MSB
  function automatic logic parity_bit(
    input logic [8:0] d,
    input logic       nine,
    input logic       odd
  );
    logic p;
    p = nine ? ^d[7:0] : ^d[6:0];
    parity_bit = p ^ odd;
  endfunction : parity_bit

  function automatic logic char_msb(input logic [8:0] d, input logic nine);
    char_msb = nine ? d[8] : d[7];
  endfunction : char_msb

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]       frame_control_reg;
  logic [7:0]       alt_event_status_reg;
  logic [7:0]       alt_irq_enable_reg;
  logic [7:0]       alt_detect_reg;
  logic [7:0]       status2_reg;
  logic [7:0]       rd_data_reg;
  logic [7:0]       rd_data_next;
  logic             irq_reg;
  logic             rx_routed_reg;
  logic             active_reg;
  logic             tx_parity_reg;
  logic             parity_error_reg;
  logic             idle_reg;
  logic             wake_reg;
  logic             rx_prev_reg;
  logic             idle_armed_reg;
  logic [3:0]       zero_cnt_reg;
  logic [3:0]       one_cnt_reg;
  logic [1:0]       pins_s;
  logic             rx_pin_s;
  logic             tx_pin_s;
  logic             rx_in;
  logic             alternate_map_select;
  logic             nine;
  logic [3:0]       frame_len;
  logic [1:0]       mm_mode;
  logic [3:0]       mm_tick;
  logic             edge_evt;
  logic             mism_evt;
  logic             break_evt;
  logic             idle_evt;
  logic             sample_ok;
  logic [7:0]       flag_set;
  logic [7:0]       flag_clr;
  sfl_pkg::sfl_sel_t wr_sel;
  sfl_pkg::sfl_sel_t rd_sel;

  sfl_pin_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pins_i    ({tx_pin_i, rx_pin_i}),
    .pins_o    (pins_s)
  );

  assign rx_pin_s  = pins_s[0];
  assign tx_pin_s  = pins_s[1];
  assign alternate_map_select      = status2_reg[sfl_pkg::S2_ALTERNATE_MAP_SELECT];
  assign nine      = frame_control_reg[sfl_pkg::FC_NINE];
  assign frame_len = nine ? sfl_pkg::FRAME_LEN9 : sfl_pkg::FRAME_LEN8;
  assign mm_mode   = alt_detect_reg[sfl_pkg::DC_MODE_LO+1:sfl_pkg::DC_MODE_LO];
  assign wr_sel    = decode(addr_i, alternate_map_select);
  assign rd_sel    = decode(addr_i, alternate_map_select);
  assign sample_ok = active_reg && rx_enable_i && rx_bit_strobe_i;

  // ----------------------------------------------------------------
  // Receive routing
  // ----------------------------------------------------------------
  // receive pin, single-wire or internal return path
  always_comb begin
    if (!frame_control_reg[sfl_pkg::FC_RETURN]) begin
      rx_in = rx_pin_s;
    end else if (frame_control_reg[sfl_pkg::FC_SRC]) begin
      rx_in = tx_pin_s;
    end else begin
      rx_in = tx_serial_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_routed_reg <= 1'b1;
    end else begin
      rx_routed_reg <= rx_in;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_reg <= 1'b1;
    end else begin
      active_reg <= !(wait_mode_i && frame_control_reg[sfl_pkg::FC_HALT]);
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // normal-bank frame control
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_control_reg <= sfl_pkg::RST_VAL;
    end else if (wr_i && wr_sel == sfl_pkg::SFL_SEL_FRAME) begin
      frame_control_reg <= wr_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      alt_irq_enable_reg <= sfl_pkg::RST_VAL;
      alt_detect_reg     <= sfl_pkg::RST_VAL;
      status2_reg        <= sfl_pkg::RST_VAL;
    end else if (wr_i) begin
      if (wr_sel == sfl_pkg::SFL_SEL_ALT_IRQ) begin
        alt_irq_enable_reg <= wr_data_i & sfl_pkg::IE_MASK;
      end
      if (wr_sel == sfl_pkg::SFL_SEL_ALT_DETECT) begin
        alt_detect_reg <= wr_data_i & sfl_pkg::DC_MASK;
      end
      if (wr_sel == sfl_pkg::SFL_SEL_STATUS2) begin
        status2_reg <= wr_data_i & sfl_pkg::S2_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= rx_pin_s;
    end
  end

  assign edge_evt = active_reg && (status2_reg[sfl_pkg::S2_RECEIVE_POLARITY] ?
                    (rx_pin_s && !rx_prev_reg) : (!rx_pin_s && rx_prev_reg));

  // sampling tick by mode; reserved mode checks nothing
  assign mm_tick  = (mm_mode == sfl_pkg::MM_EARLY) ? sfl_pkg::TICK_EARLY
                                                   : sfl_pkg::TICK_LATE;
  assign mism_evt = active_reg && tx_busy_i && tx_tick_i &&
                    (mm_mode == sfl_pkg::MM_EARLY ||
                     mm_mode == sfl_pkg::MM_LATE) &&
                    tx_tick_num_i == mm_tick && rx_in != tx_serial_i;

  // Break is a whole frame of zeros, stop bit included
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      zero_cnt_reg <= sfl_pkg::CNT_ZERO;
    end else if (sample_ok) begin
      if (rx_in) begin
        zero_cnt_reg <= sfl_pkg::CNT_ZERO;
      end else if (zero_cnt_reg != frame_len) begin
        zero_cnt_reg <= zero_cnt_reg + sfl_pkg::CNT_ONE;
      end
    end
  end

  // break when zero run reaches frame length
  assign break_evt = sample_ok && !rx_in &&
                     alt_detect_reg[sfl_pkg::DC_BREAK_EN] &&
                     (zero_cnt_reg + sfl_pkg::CNT_ONE) == frame_len;

  // ----------------------------------------------------------------
  // Alternate status flags
  // ----------------------------------------------------------------
  always_comb begin
    flag_set                   = sfl_pkg::RST_VAL;
    flag_set[sfl_pkg::AS_EDGE]  = edge_evt;
    flag_set[sfl_pkg::AS_MISM]  = mism_evt;
    flag_set[sfl_pkg::AS_BREAK] = break_evt;
    flag_clr = (wr_i && wr_sel == sfl_pkg::SFL_SEL_ALT_STATUS) ?
               (wr_data_i & sfl_pkg::AS_FLAG_MASK) : sfl_pkg::RST_VAL;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      alt_event_status_reg <= sfl_pkg::RST_VAL;
    end else begin
      alt_event_status_reg <= ((alt_event_status_reg & ~flag_clr) | flag_set)
                              & sfl_pkg::AS_FLAG_MASK;
      // capture sampled level with the flag
      if (mism_evt) begin
        alt_event_status_reg[sfl_pkg::AS_MVAL] <= rx_in;
      end else begin
        alt_event_status_reg[sfl_pkg::AS_MVAL] <=
          alt_event_status_reg[sfl_pkg::AS_MVAL];
      end
    end
  end

  // level request while flag and enable set
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(alt_event_status_reg & alt_irq_enable_reg &
                   sfl_pkg::AS_FLAG_MASK);
    end
  end

  // ----------------------------------------------------------------
  // Parity, idle and wakeup
  // ----------------------------------------------------------------
  // parity in MSB
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_parity_reg    <= 1'b0;
      parity_error_reg <= 1'b0;
    end else begin
      tx_parity_reg <= frame_control_reg[sfl_pkg::FC_PAR_ON] &&
                       parity_bit(tx_char_i, nine,
                                  frame_control_reg[sfl_pkg::FC_PAR_ODD]);
      parity_error_reg <= active_reg && rx_char_valid_i &&
                          frame_control_reg[sfl_pkg::FC_PAR_ON] &&
                          (char_msb(rx_char_i, nine) !=
                           parity_bit(rx_char_i, nine,
                                      frame_control_reg[sfl_pkg::FC_PAR_ODD]));
    end
  end

  // idle counting starts after start or stop
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_armed_reg <= 1'b0;
      one_cnt_reg    <= sfl_pkg::CNT_ZERO;
    end else begin
      if (rx_stop_i) begin
        idle_armed_reg <= 1'b1;
      end else if (sample_ok && !rx_in) begin
        idle_armed_reg <= 1'b0;
      end
      if (sample_ok) begin
        if (!rx_in) begin
          one_cnt_reg <= sfl_pkg::CNT_ZERO;
        end else if ((idle_armed_reg || !frame_control_reg[sfl_pkg::FC_IDLE])
                     && one_cnt_reg != frame_len) begin
          one_cnt_reg <= one_cnt_reg + sfl_pkg::CNT_ONE;
        end
      end
    end
  end

  assign idle_evt = sample_ok && rx_in &&
                    (idle_armed_reg || !frame_control_reg[sfl_pkg::FC_IDLE]) &&
                    (one_cnt_reg + sfl_pkg::CNT_ONE) == frame_len;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      idle_reg <= idle_evt;
      wake_reg <= frame_control_reg[sfl_pkg::FC_WAKE] ?
                  (active_reg && rx_char_valid_i &&
                   char_msb(rx_char_i, nine)) : idle_evt;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    case (rd_sel)
      sfl_pkg::SFL_SEL_FRAME:      rd_data_next = frame_control_reg;
      sfl_pkg::SFL_SEL_ALT_STATUS: rd_data_next = alt_event_status_reg;
      sfl_pkg::SFL_SEL_ALT_IRQ:    rd_data_next = alt_irq_enable_reg;
      sfl_pkg::SFL_SEL_ALT_DETECT: rd_data_next = alt_detect_reg;
      sfl_pkg::SFL_SEL_STATUS2:    rd_data_next = status2_reg;
      default:                     rd_data_next = sfl_pkg::RST_VAL;
    endcase
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_reg <= sfl_pkg::RST_VAL;
    end else begin
      rd_data_reg <= rd_i ? rd_data_next : sfl_pkg::RST_VAL;
    end
  end

  assign rd_data_o       = rd_data_reg;
  assign irq_o           = irq_reg;
  assign rx_routed_o     = rx_routed_reg;
  assign module_enable_o = active_reg;
  assign nine_bit_o      = frame_control_reg[sfl_pkg::FC_NINE];
  assign parity_on_o     = frame_control_reg[sfl_pkg::FC_PAR_ON];
  assign tx_parity_o     = tx_parity_reg;
  assign parity_error_o  = parity_error_reg;
  assign idle_detect_o   = idle_reg;
  assign wake_o          = wake_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  loop_internal_a: assert property (
    frame_control_reg[sfl_pkg::FC_RETURN] && !frame_control_reg[sfl_pkg::FC_SRC]
    |=> rx_routed_o == $past(tx_serial_i))
    else $error("loop return not routed from transmitter");

  single_wire_a: assert property (
    frame_control_reg[sfl_pkg::FC_RETURN] && frame_control_reg[sfl_pkg::FC_SRC]
    |=> rx_routed_o == $past(tx_pin_s))
    else $error("single-wire return not taken from transmit pin");

  wait_halt_a: assert property (
    wait_mode_i && frame_control_reg[sfl_pkg::FC_HALT] |=> !module_enable_o)
    else $error("block not halted in wait mode");

  bank_guard_a: assert property (
    alternate_map_select && wr_i && addr_i == sfl_pkg::OFS_FRAME |=> $stable(frame_control_reg))
    else $error("frame control written in alternate bank");

  edge_flag_a: assert property (
    edge_evt |=> alt_event_status_reg[sfl_pkg::AS_EDGE])
    else $error("active edge did not set edge flag");

  mismatch_cap_a: assert property (
    mism_evt |=> alt_event_status_reg[sfl_pkg::AS_MISM] &&
                 alt_event_status_reg[sfl_pkg::AS_MVAL] == $past(rx_in))
    else $error("mismatch flag or value not captured");

  mismatch_off_a: assert property (
    mm_mode == sfl_pkg::MM_OFF && !(wr_i && wr_sel ==
    sfl_pkg::SFL_SEL_ALT_STATUS) ##1 $rose(alt_event_status_reg[sfl_pkg::AS_MISM])
    |-> 1'b0)
    else $error("mismatch flagged with checking off");

  break_len_a: assert property (
    $rose(alt_event_status_reg[sfl_pkg::AS_BREAK]) |->
    $past(zero_cnt_reg) + sfl_pkg::CNT_ONE == $past(frame_len))
    else $error("break flagged at wrong zero count");

  irq_hold_a: assert property (
    |(alt_event_status_reg & alt_irq_enable_reg) [*2] |-> irq_o)
    else $error("interrupt dropped while flag enabled");

  addr_wake_a: assert property (
    frame_control_reg[sfl_pkg::FC_WAKE] && active_reg && rx_char_valid_i &&
    char_msb(rx_char_i, nine) |=> wake_o)
    else $error("address mark did not wake receiver");
endmodule : sfl_top
`default_nettype wire

// >>> tb/sfl_remote_node.sv
// Remote serial node that drives the receive pin
`timescale 1ns/1ps
`default_nettype none
module sfl_remote_node (
  input  wire logic       sys_clk_i,
  input  wire logic       go_i,
  input  wire logic       brk_i,
  input  wire logic [7:0] byte_i,
  output logic            rx_pin_o
);
  logic [9:0] sh_reg;
  logic [3:0] cnt_reg;
  initial begin
    sh_reg  = 10'h3FF;
    cnt_reg = 4'h0;
  end
  // Mark level when idle; break holds the line low
  assign rx_pin_o = brk_i ? 1'b0 : sh_reg[0];
  // Start, eight data bits LSB first, stop; 16 clocks a bit
  always @(posedge sys_clk_i) begin
    if (go_i) begin
      sh_reg  <= {1'b1, byte_i, 1'b0};
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg == 4'hF) begin
        sh_reg <= {1'b1, sh_reg[9:1]};
      end
    end
  end
endmodule : sfl_remote_node
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the frame and alternate status block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wr_data_i = 8'h00, byte_v = 8'hFF;
  logic tx_pin_i = 1'b1, tx_serial_i = 1'b1, tx_busy_i = 1'b1;
  logic tx_tick_i = 1'b0, rx_enable_i = 1'b1, rx_bit_strobe_i = 1'b0;
  logic rx_stop_i = 1'b0, rx_char_valid_i = 1'b0, wait_mode_i = 1'b0;
  logic go = 1'b0, brk = 1'b0;
  logic [3:0] tx_tick_num_i = 4'h1;
  logic [8:0] rx_char_i = 9'h000, tx_char_i = 9'h000;
  logic [7:0] rd_data_o;
  logic irq_o, rx_routed_o, module_enable_o, nine_bit_o, parity_on_o;
  logic tx_parity_o, parity_error_o, idle_detect_o, wake_o;
  wire rx_pin_i;
  int mismatches = 0, tests_run = 0, cyc = 0;
  logic [6:0]  pat [4] = '{7'h00, 7'h01, 7'h3F, 7'h55};
  logic [10:0] lp  [6] = '{11'h400, 11'h405, 11'h504,
                           11'h503, 11'h101, 11'h001};
  always #25 sys_clk_i = ~sys_clk_i;
  sfl_top dut_u (.sys_clk_i, .rst_i, .addr_i, .wr_data_i, .wr_i, .rd_i,
    .rd_data_o, .irq_o, .rx_pin_i, .tx_pin_i, .tx_serial_i, .tx_busy_i,
    .tx_tick_i, .tx_tick_num_i, .rx_enable_i, .rx_bit_strobe_i,
    .rx_stop_i, .rx_char_valid_i, .rx_char_i, .tx_char_i, .wait_mode_i,
    .rx_routed_o, .module_enable_o, .nine_bit_o, .parity_on_o,
    .tx_parity_o, .parity_error_o, .idle_detect_o, .wake_o);
  sfl_remote_node node_u (.sys_clk_i, .go_i(go), .brk_i(brk),
    .byte_i(byte_v), .rx_pin_o(rx_pin_i));
  // ------------------------------------------------------------
  // Bus, wait and check helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : w
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rd_data_o, e);
  endtask : rc
  task automatic tick(input logic [3:0] n);
    @(posedge sys_clk_i);
    tx_tick_i     <= 1'b1;
    tx_tick_num_i <= n;
    @(posedge sys_clk_i);
    tx_tick_i <= 1'b0;
  endtask : tick
  task automatic strb(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      rx_bit_strobe_i <= 1'b1;
      @(posedge sys_clk_i);
      rx_bit_strobe_i <= 1'b0;
    end
    #1;
  endtask : strb
  task automatic rxc(input logic [8:0] c, input logic [7:0] e);
    @(posedge sys_clk_i);
    rx_char_i       <= c;
    rx_char_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    rx_char_valid_i <= 1'b0;
    #1;
    chk({6'h00, parity_error_o, wake_o}, e);
  endtask : rxc
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // Whole run needs well under 2000 cycles
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    w(20);
    rst_i <= 1'b0;
    w(1);
    chk({5'h00, irq_o, rx_routed_o, module_enable_o}, 8'h03);
    rc(3'h2, 8'h00);
    wr(3'h2, 8'h13);
    rc(3'h2, 8'h13);
    chk({6'h00, nine_bit_o, parity_on_o}, 8'h03);
    $display("test reset and frame control done");
    for (int i = 0; i < 8; i++) begin
      wr(3'h2, {6'h00, 1'b1, i[2]});
      tx_char_i <= {2'b00, pat[i[1:0]]};
      w(3);
      chk({7'h00, tx_parity_o}, {7'h00, ^pat[i[1:0]] ^ i[2]});
    end
    tx_char_i <= 9'h001;
    wr(3'h2, 8'h00);
    w(3);
    chk({7'h00, tx_parity_o}, 8'h00);
    $display("test parity done");
    for (int i = 0; i < 6; i++) begin
      wr(3'h2, lp[i][10:3]);
      tx_serial_i <= lp[i][2];
      tx_pin_i    <= lp[i][1];
      w(5);
      chk({7'h00, rx_routed_o}, {7'h00, lp[i][0]});
    end
    tx_serial_i <= 1'b1;
    wr(3'h2, 8'h40);
    wait_mode_i <= 1'b1;
    w(3);
    chk({7'h00, module_enable_o}, 8'h00);
    wr(3'h2, 8'h00);
    w(3);
    chk({7'h00, module_enable_o}, 8'h01);
    wait_mode_i <= 1'b0;
    $display("test routing and wait done");
    wr(3'h5, 8'h80);
    rc(3'h5, 8'h80);
    rc(3'h0, 8'h00);
    rc(3'h3, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h1, 8'h83);
    go <= 1'b1;
    w(1);
    go <= 1'b0;
    w(6);
    rc(3'h0, 8'h80);
    chk({7'h00, irq_o}, 8'h01);
    wr(3'h0, 8'h00);
    rc(3'h0, 8'h80);
    wr(3'h0, 8'h80);
    rc(3'h0, 8'h00);
    w(2);
    chk({7'h00, irq_o}, 8'h00);
    wr(3'h5, 8'h88);
    byte_v <= 8'h00;
    go     <= 1'b1;
    w(1);
    go <= 1'b0;
    w(20);
    rc(3'h0, 8'h00);
    w(150);
    rc(3'h0, 8'h80);
    wr(3'h0, 8'h80);
    wr(3'h5, 8'h80);
    $display("test edge flag done");
    wr(3'h2, 8'h02);
    tx_serial_i <= 1'b0;
    tick(4'hD);
    rc(3'h0, 8'h00);
    tick(4'h9);
    rc(3'h0, 8'h06);
    chk({7'h00, irq_o}, 8'h01);
    wr(3'h0, 8'h02);
    wr(3'h2, 8'h04);
    tx_serial_i <= 1'b1;
    brk         <= 1'b1;
    tick(4'h9);
    tick(4'hD);
    rc(3'h0, 8'h82);
    $display("test mismatch done");
    wr(3'h0, 8'h83);
    wr(3'h2, 8'h01);
    strb(9);
    rc(3'h0, 8'h00);
    strb(1);
    brk <= 1'b0;
    rc(3'h0, 8'h01);
    chk({7'h00, irq_o}, 8'h01);
    wr(3'h1, 8'h00);
    w(2);
    chk({7'h00, irq_o}, 8'h00);
    wr(3'h0, 8'h01);
    rc(3'h0, 8'h00);
    $display("test break done");
    wr(3'h5, 8'h00);
    wr(3'h2, 8'h0A);
    rxc(9'h081, 8'h01);
    rxc(9'h080, 8'h03);
    rxc(9'h001, 8'h02);
    wr(3'h2, 8'h0B);
    rxc(9'h001, 8'h00);
    wr(3'h2, 8'h1A);
    rxc(9'h101, 8'h01);
    rxc(9'h081, 8'h00);
    $display("test parity check and address wake done");
    wr(3'h2, 8'h00);
    strb(9);
    chk({6'h00, idle_detect_o, wake_o}, 8'h00);
    strb(1);
    chk({6'h00, idle_detect_o, wake_o}, 8'h03);
    wr(3'h2, 8'h04);
    brk <= 1'b1;
    w(3);
    strb(1);
    brk <= 1'b0;
    w(3);
    strb(10);
    chk({6'h00, idle_detect_o, wake_o}, 8'h00);
    rx_stop_i <= 1'b1;
    w(1);
    rx_stop_i <= 1'b0;
    strb(10);
    chk({6'h00, idle_detect_o, wake_o}, 8'h03);
    $display("test idle and wake done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
